// file: core/flash_cmd_pkg.sv
// Purpose: Shared opcodes, address fields and command classes for the
//          serial flash read and buffer load front end.
// Assumes: Both link ends import this package.
// Notes: The opcode decides dummy bytes; the command class decides address stepping.
package flash_cmd_pkg;
   localparam logic [7:0] OP_READ_FAST = 8'h0b;
   localparam logic [7:0] OP_READ_SLOW = 8'h03;
   localparam logic [7:0] OP_PAGE_READ = 8'hd2;
   localparam logic [7:0] OP_BUF_READ_FAST = 8'hd4;
   localparam logic [7:0] OP_BUF_READ_SLOW = 8'hd1;
   localparam logic [7:0] OP_BUF_WRITE = 8'h84;
   localparam int ADDR_W = 24;
   localparam int PAGE_W = 10;
   localparam int BYTE_W = 9;
   localparam int WIDE_PAGE_LSB = 9;
   localparam int NARROW_PAGE_LSB = 8;
   localparam int BUF_BYTES = 264;
   localparam logic [8:0] LAST_BYTE_WIDE = 9'h107;
   localparam logic [8:0] LAST_BYTE_NARROW = 9'h0ff;
   localparam logic [2:0] MSB_BIT = 3'h7;
   localparam logic [2:0] LSB_BIT = 3'h0;
   localparam logic [2:0] ADDR_BYTES = 3'h3;
   localparam logic [2:0] DUMMY_NONE = 3'h0;
   localparam logic [2:0] DUMMY_ONE = 3'h1;
   localparam logic [2:0] DUMMY_PAGE = 3'h4;
   localparam logic [7:0] FILL_BYTE = 8'h00;

   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_ARRAY = 3'h1,
      CMD_PAGE = 3'h2,
      CMD_BUF_RD = 3'h3,
      CMD_BUF_WR = 3'h4
   } cmd_class_t;

   function automatic cmd_class_t cmd_class(input logic [7:0] op);
      cmd_class_t c;
      c = CMD_NONE;
      if (op == OP_READ_FAST || op == OP_READ_SLOW) c = CMD_ARRAY;
      if (op == OP_PAGE_READ) c = CMD_PAGE;
      if (op == OP_BUF_READ_FAST || op == OP_BUF_READ_SLOW) c = CMD_BUF_RD;
      if (op == OP_BUF_WRITE) c = CMD_BUF_WR;
      return c;
   endfunction : cmd_class

   function automatic logic [2:0] dummy_bytes(input logic [7:0] op);
      logic [2:0] n;
      n = DUMMY_NONE;
      if (op == OP_READ_FAST) n = DUMMY_ONE;
      if (op == OP_PAGE_READ) n = DUMMY_PAGE;
      if (cmd_class(op) == CMD_BUF_RD) n = DUMMY_ONE;
      return n;
   endfunction : dummy_bytes
endpackage : flash_cmd_pkg

// file: core/spi_link_if.sv
// Purpose: Serial link between the flash host end and the device end.
// Assumes: The host makes the serial clock; the device drives so_out.
// Notes: While released, so shows the inverse of the last driven bit,
//        so a host that samples it out of turn reads wrong data.
`timescale 1ns/10ps
interface spi_link_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so_out;
   logic so_oe;
   wire so;

   assign so = so_oe ? so_out : ~so_out;

   modport host (output cs_n, output sck, output si, input so);
   modport dev (input cs_n, input sck, input si, output so_out,
      output so_oe);
endinterface : spi_link_if

// file: core/sync2.sv
// Purpose: Two-flop level synchroniser.
// Assumes: Inputs are slow levels from another clock domain.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '0;
         q <= '0;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule : sync2

// file: core/flash_dev_end.sv
// Purpose: Device end of the serial flash link: array reads, page
//          reads, buffer reads and buffer loads.
// Assumes: Mode 0 link; bits are taken on rising sck and driven on
//          falling sck; array_rdata follows the array address
//          combinationally within half a link clock.
// Notes: Everything here runs on the link clock.
// Functional notes
// - Fast array read: opcode, address, one dummy.
// - Slow array read: data right after address.
// - 264 mode: 10 page bits, 9 byte bits.
// - 256 mode: bits 17-8 page, 7-0 byte.
// - Page end rolls into next page seamlessly.
// - Array end wraps to page zero seamlessly.
// - Host keeps select low for whole read.
// - Select rise ends read, output floats.
// - Array reads never alter the buffer.
// - Page read: address, four dummies, then data.
// - Page read wraps within the same page.
// - Two buffer read opcodes, fast and slow.
// - 264 mode buffer index: low 9 bits.
// - 256 mode buffer index: low 8 bits.
// - One dummy byte before buffer read data.
// - Buffer read wraps to byte zero.
// - Buffer write stores bytes at rising addresses.
// - Buffer write wraps to location zero.
// - Buffer loading stops when select rises.
// - All fields travel most significant bit first.
// - Command starts at select fall with opcode.
`timescale 1ns/10ps
module flash_dev_end
   import flash_cmd_pkg::*;
#(
   parameter int PAGES = 1024
) (
   input wire logic rst_n,
   input wire logic ce,
   input wire logic page_264,
   spi_link_if.dev link,
   output logic [flash_cmd_pkg::PAGE_W-1:0] array_page_ff,
   output logic [flash_cmd_pkg::BYTE_W-1:0] array_byte_ff,
   input wire logic [7:0] array_rdata
);
   import flash_cmd_pkg::*;

   typedef enum logic [1:0] {
      ST_OP = 2'b00,
      ST_ADDR = 2'b01,
      ST_DUMMY = 2'b11,
      ST_DATA = 2'b10
   } dev_state_t;

   localparam logic [PAGE_W-1:0] LAST_PAGE = PAGE_W'(PAGES - 1);

   dev_state_t state_ff;
   cmd_class_t cls_ff;
   logic [2:0] bit_ff;
   logic [2:0] cnt_ff;
   logic [2:0] dummy_ff;
   logic [ADDR_W-1:0] shift_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [7:0] buf_mem [BUF_BYTES];
   logic ce_s;
   logic wide_s;
   logic frm_rst_n;
   logic byte_end;
   logic enter_data;
   logic data_byte_end;
   logic is_read;
   logic [ADDR_W-1:0] nxt_addr;
   logic [ADDR_W-1:0] start_addr;
   logic [8:0] last_byte;
   logic [7:0] src_byte;

   // Config and enable come from the user clock domain.
   sync2 #(
      .WIDTH(2)
   ) u_cfg_sync (
      .clk(link.sck),
      .rst_n(rst_n),
      .d({ce, page_264}),
      .q({ce_s, wide_s})
   );

   // A high select holds the frame logic in reset, so a rising select
   // ends any command at once without waiting for a link clock edge.
   assign frm_rst_n = rst_n & ~link.cs_n;

   assign nxt_addr = {shift_ff[ADDR_W-2:0], link.si};
   assign byte_end = (bit_ff == LSB_BIT);
   assign enter_data = byte_end &&
      ((state_ff == ST_ADDR && cnt_ff == ADDR_BYTES - 3'h1 &&
        dummy_ff == DUMMY_NONE) ||
       (state_ff == ST_DUMMY && cnt_ff == dummy_ff - 3'h1));
   assign data_byte_end = byte_end && state_ff == ST_DATA;
   assign start_addr = (state_ff == ST_ADDR) ? nxt_addr : addr_ff;
   // The layout input is synchronised on the link clock, so it must only
   // change while the link is idle, and one frame must pass before use.
   assign last_byte = wide_s ? LAST_BYTE_WIDE : LAST_BYTE_NARROW;
   assign is_read = cls_ff == CMD_ARRAY || cls_ff == CMD_PAGE ||
      cls_ff == CMD_BUF_RD;
   assign src_byte = (cls_ff == CMD_BUF_RD) ? buf_mem[array_byte_ff]
      : array_rdata;

   // Bit counter and serial input shifter.
   always_ff @(posedge link.sck or negedge frm_rst_n) begin
      if (!frm_rst_n) begin
         bit_ff <= MSB_BIT;
         shift_ff <= '0;
      end else if (ce_s) begin
         bit_ff <= bit_ff - 3'h1;
         shift_ff <= nxt_addr;
      end
   end

   // Command phase sequencing: opcode, address, dummies, data.
   always_ff @(posedge link.sck or negedge frm_rst_n) begin
      if (!frm_rst_n) begin
         state_ff <= ST_OP;
         cls_ff <= CMD_NONE;
         cnt_ff <= 3'h0;
         dummy_ff <= DUMMY_NONE;
         addr_ff <= '0;
      end else if (ce_s && byte_end) begin
         unique case (state_ff)
            ST_OP: begin
               cls_ff <= cmd_class(nxt_addr[7:0]);
               dummy_ff <= dummy_bytes(nxt_addr[7:0]);
               cnt_ff <= 3'h0;
               state_ff <= ST_ADDR;
            end
            ST_ADDR: begin
               cnt_ff <= cnt_ff + 3'h1;
               if (cnt_ff == ADDR_BYTES - 3'h1) begin
                  addr_ff <= nxt_addr;
                  cnt_ff <= 3'h0;
                  if (dummy_ff == DUMMY_NONE) begin
                     state_ff <= ST_DATA;
                  end else begin
                     state_ff <= ST_DUMMY;
                  end
               end
            end
            ST_DUMMY: begin
               cnt_ff <= cnt_ff + 3'h1;
               if (enter_data) begin
                  state_ff <= ST_DATA;
               end
            end
            ST_DATA: begin
               cnt_ff <= cnt_ff;
            end
         endcase
      end
   end

   // Address decode at data start, then stepping after every data byte of a known command.
   always_ff @(posedge link.sck or negedge frm_rst_n) begin
      if (!frm_rst_n) begin
         array_page_ff <= '0;
         array_byte_ff <= '0;
      end else if (ce_s) begin
         if (enter_data) begin
            if (wide_s) begin
               array_page_ff <= start_addr[WIDE_PAGE_LSB +: PAGE_W];
               array_byte_ff <= start_addr[BYTE_W-1:0];
            end else begin
               array_page_ff <= start_addr[NARROW_PAGE_LSB +: PAGE_W];
               array_byte_ff <=
                  BYTE_W'(start_addr[NARROW_PAGE_LSB-1:0]);
            end
         end else if (data_byte_end && cls_ff != CMD_NONE) begin
            // Out-of-range start bytes in the wide layout wrap as well.
            if (array_byte_ff >= last_byte) begin
               array_byte_ff <= '0;
               if (cls_ff == CMD_ARRAY) begin
                  if (array_page_ff == LAST_PAGE) begin
                     array_page_ff <= '0;
                  end else begin
                     array_page_ff <= array_page_ff + 1'b1;
                  end
               end
            end else begin
               array_byte_ff <= array_byte_ff + 1'b1;
            end
         end
      end
   end

   // Only buffer write commands touch the buffer; a byte is stored only
   // once all eight bits have arrived, so a cut-off byte is lost.
   always_ff @(posedge link.sck) begin
      if (ce_s && data_byte_end && cls_ff == CMD_BUF_WR) begin
         buf_mem[array_byte_ff] <= nxt_addr[7:0];
      end
   end

   // Read data leaves on the falling edge, most significant bit first.
   always_ff @(negedge link.sck or negedge frm_rst_n) begin
      if (!frm_rst_n) begin
         link.so_out <= 1'b0;
         link.so_oe <= 1'b0;
      end else if (ce_s) begin
         link.so_oe <= (state_ff == ST_DATA) && is_read;
         link.so_out <= src_byte[bit_ff];
      end
   end
endmodule : flash_dev_end

// file: core/flash_host_end.sv
// Purpose: Host end of the serial flash link; runs one command per start.
// Assumes: Mode 0; sck is made here by dividing clk.
// Notes: SCK_HALF must be at least 3 so synchronised data is settled.
`timescale 1ns/10ps
module flash_host_end
   import flash_cmd_pkg::*;
#(
   parameter int SCK_HALF = 4,
   parameter int CNT_W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic start,
   input wire logic [7:0] opcode,
   input wire logic [flash_cmd_pkg::ADDR_W-1:0] address,
   input wire logic [CNT_W-1:0] data_count,
   input wire logic [7:0] wr_data,
   output logic busy_ff,
   output logic [7:0] rd_data_ff,
   output logic rd_valid_ff,
   output logic wr_taken_ff,
   spi_link_if.host link
);
   import flash_cmd_pkg::*;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SHIFT = 2'b01,
      H_STOP = 2'b11
   } host_state_t;

   localparam int NB_W = CNT_W + 1;
   localparam logic [7:0] DIV_LAST = 8'(SCK_HALF - 1);

   host_state_t state_ff;
   cmd_class_t cls_ff;
   logic [7:0] div_ff;
   logic [2:0] bit_ff;
   logic [7:0] tx_ff;
   logic [7:0] rx_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [NB_W-1:0] byte_ff;
   logic [NB_W-1:0] first_data_ff;
   logic [NB_W-1:0] last_ff;
   logic so_s;
   logic tick;
   logic [NB_W-1:0] nb;
   logic in_data_next;
   logic [7:0] nxt_tx;

   sync2 #(
      .WIDTH(1)
   ) u_so_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(link.so),
      .q(so_s)
   );

   assign tick = state_ff != H_IDLE && div_ff == DIV_LAST;
   assign nb = byte_ff + 1'b1;
   assign in_data_next = nb >= first_data_ff;
   always_comb begin
      nxt_tx = FILL_BYTE;
      if (nb <= NB_W'(ADDR_BYTES)) nxt_tx = addr_ff[ADDR_W-1 -: 8];
      else if (in_data_next && cls_ff == CMD_BUF_WR) nxt_tx = wr_data;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_ff <= 8'h00;
      end else if (ce) begin
         div_ff <= (state_ff == H_IDLE || tick) ? 8'h00 : div_ff + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= H_IDLE;
         cls_ff <= CMD_NONE;
         busy_ff <= 1'b0;
         link.cs_n <= 1'b1;
         link.sck <= 1'b0;
         link.si <= 1'b0;
         bit_ff <= MSB_BIT;
         tx_ff <= 8'h00;
         rx_ff <= 8'h00;
         addr_ff <= '0;
         byte_ff <= '0;
         first_data_ff <= '0;
         last_ff <= '0;
         rd_data_ff <= 8'h00;
         rd_valid_ff <= 1'b0;
         wr_taken_ff <= 1'b0;
      end else if (ce) begin
         rd_valid_ff <= 1'b0;
         wr_taken_ff <= 1'b0;
         unique case (state_ff)
            H_IDLE: begin
               if (start) begin
                  cls_ff <= cmd_class(opcode);
                  busy_ff <= 1'b1;
                  link.cs_n <= 1'b0;
                  tx_ff <= opcode;
                  link.si <= opcode[7];
                  bit_ff <= MSB_BIT;
                  addr_ff <= address;
                  byte_ff <= '0;
                  first_data_ff <= NB_W'(ADDR_BYTES) + 1'b1 +
                     NB_W'(dummy_bytes(opcode));
                  last_ff <= NB_W'(ADDR_BYTES) + NB_W'(dummy_bytes(opcode))
                     + NB_W'(data_count);
                  state_ff <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               if (tick && !link.sck) begin
                  link.sck <= 1'b1;
                  rx_ff <= {rx_ff[6:0], so_s};
               end else if (tick) begin
                  link.sck <= 1'b0;
                  if (bit_ff != LSB_BIT) begin
                     bit_ff <= bit_ff - 3'h1;
                     tx_ff <= {tx_ff[6:0], 1'b0};
                     link.si <= tx_ff[6];
                  end else begin
                     if (byte_ff >= first_data_ff && cls_ff != CMD_BUF_WR
                        && cls_ff != CMD_NONE) begin
                        rd_data_ff <= rx_ff;
                        rd_valid_ff <= 1'b1;
                     end
                     if (byte_ff == last_ff) begin
                        state_ff <= H_STOP;
                     end else begin
                        byte_ff <= nb;
                        bit_ff <= MSB_BIT;
                        tx_ff <= nxt_tx;
                        link.si <= nxt_tx[7];
                        if (nb <= NB_W'(ADDR_BYTES)) begin
                           addr_ff <= {addr_ff[ADDR_W-9:0], 8'h00};
                        end
                        wr_taken_ff <= in_data_next && cls_ff == CMD_BUF_WR;
                     end
                  end
               end
            end
            H_STOP: begin
               // Select stays low through the last bit of the command.
               if (tick) begin
                  link.cs_n <= 1'b1;
                  busy_ff <= 1'b0;
                  state_ff <= H_IDLE;
               end
            end
            default: begin
               state_ff <= H_IDLE;
            end
         endcase
      end
   end
endmodule : flash_host_end

// file: sim/serial_flash_read_and_buffer_load_properties.sv
// Purpose: Wire-level checks on the link between the two flash ends.
// Assumes: sck is made from clk, so every link event is seen on clk.
// Notes: The header length is worked out again from the opcode on si.
`timescale 1ns/10ps
module flash_link_checker #(
   parameter int SCK_HALF = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so_out,
   input wire logic so_oe
);
   logic sck_ff;
   logic [7:0] op_ff;
   logic [15:0] edges_ff;
   logic [15:0] hdr;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) sck_ff <= 1'b0;
      else sck_ff <= sck;
   end

   // Counting rising sck per frame ties output timing to header length.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) edges_ff <= 16'h0000;
      else if (cs_n) edges_ff <= 16'h0000;
      else if (sck && !sck_ff) edges_ff <= edges_ff + 16'h0001;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) op_ff <= 8'h00;
      else if (cs_n) op_ff <= 8'h00;
      else if (sck && !sck_ff && edges_ff < 16'h0008) begin
         op_ff <= {op_ff[6:0], si};
      end
   end

   always_comb begin
      case (op_ff)
         8'h03: hdr = 16'h0020;
         8'h0b, 8'hd4, 8'hd1: hdr = 16'h0028;
         8'hd2: hdr = 16'h0040;
         default: hdr = 16'h0000;
      endcase
   end

   chk_float_idle: assert property (cs_n |-> !so_oe)
      else $error("data out driven while deselected");
   chk_sck_rest: assert property (cs_n |-> !sck)
      else $error("serial clock high while deselected");
   chk_si_on_low: assert property (!cs_n && $changed(si) |-> !sck)
      else $error("serial input moved while clock high");
   chk_so_on_low: assert property (so_oe && $changed(so_out) |-> !sck)
      else $error("serial output moved while clock high");
   chk_data_start: assert property
      ($rose(so_oe) |-> !sck && edges_ff == hdr && hdr != 16'h0000)
      else $error("read data started after wrong header length");
   chk_oe_holds: assert property ($fell(so_oe) |-> cs_n)
      else $error("output stream stopped while still selected");
   chk_quiet_write: assert property
      (hdr == 16'h0000 && edges_ff >= 16'h0008 |-> !so_oe)
      else $error("output driven for a command with no read data");
   chk_whole_bytes: assert property
      ($rose(cs_n) |-> edges_ff[2:0] == 3'h0 && edges_ff >= 16'h0008)
      else $error("frame ended on a partial byte");
endmodule : flash_link_checker

// file: sim/serial_flash_read_and_buffer_load_tb_top.sv
// Purpose: Runs reads, page reads and buffer loads across the link.
// Assumes: A four-page array keeps the wrap checks short.
// Notes: Array bytes are a pattern of page and byte index.
`timescale 1ns/10ps
module serial_flash_read_and_buffer_load_tb_top;
   import flash_cmd_pkg::*;
   localparam int PAGES = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic start = 1'b0;
   logic page_264 = 1'b0;
   logic [7:0] opcode = 8'h00;
   logic [23:0] address = 24'h000000;
   logic [15:0] data_count = 16'h0000;
   logic [7:0] wr_data = 8'h00;
   logic ce = 1'b1;
   int freeze_at = -1;
   logic busy_ff;
   logic [7:0] rd_data_ff;
   logic rd_valid_ff;
   logic wr_taken_ff;
   logic [9:0] array_page_ff;
   logic [8:0] array_byte_ff;
   logic oe_seen;
   logic [7:0] got[$];
   logic [7:0] exp[$];
   logic [7:0] wq[$];
   int fails = 0;
   int compares = 0;

   function automatic logic [7:0] pat(input logic [9:0] p,
         input logic [8:0] b);
      return {p[2:0], 5'h00} ^ b[7:0] ^ {b[8], 7'h00};
   endfunction : pat

   spi_link_if link ();
   always #50 clk = ~clk;

   flash_host_end #(.SCK_HALF(4), .CNT_W(16)) u_flash_host_end (.clk(clk),
      .rst_n(rst_n), .ce(ce), .start(start), .opcode(opcode),
      .address(address), .data_count(data_count), .wr_data(wr_data),
      .busy_ff(busy_ff), .rd_data_ff(rd_data_ff),
      .rd_valid_ff(rd_valid_ff), .wr_taken_ff(wr_taken_ff),
      .link(link.host));
   flash_dev_end #(.PAGES(PAGES)) u_flash_dev_end (.rst_n(rst_n),
      .ce(ce), .page_264(page_264), .link(link.dev),
      .array_page_ff(array_page_ff), .array_byte_ff(array_byte_ff),
      .array_rdata(pat(array_page_ff, array_byte_ff)));
   flash_link_checker #(.SCK_HALF(4)) u_flash_link_checker (.clk(clk),
      .rst_n(rst_n), .cs_n(link.cs_n), .sck(link.sck), .si(link.si),
      .so_out(link.so_out), .so_oe(link.so_oe));

   task automatic tally_and_finish();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] want);
      compares++;
      if (seen !== want) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, want, seen);
      end
   endtask : check

   // Bounded so that a stuck busy ends the run instead of hanging it.
   task automatic cmd(input logic [7:0] op, input logic [23:0] a,
         input int n);
      int k;
      logic sck_was;
      logic frozen_bad;
      got = {};
      oe_seen = 1'b0;
      @(negedge clk);
      opcode = op;
      address = a;
      data_count = 16'(n);
      wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      k = 0;
      while (busy_ff !== 1'b0 && k < 4000) begin
         @(negedge clk);
         k++;
         if (link.so_oe === 1'b1) oe_seen = 1'b1;
         if (rd_valid_ff === 1'b1) got.push_back(rd_data_ff);
         if (wr_taken_ff === 1'b1 && wq.size() > 0) begin
            void'(wq.pop_front());
            wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
         end
         if (k == freeze_at) begin
            ce = 1'b0;
            sck_was = link.sck;
            frozen_bad = 1'b0;
            repeat (20) begin
               @(negedge clk);
               if (link.sck !== sck_was || link.cs_n !== 1'b0 ||
                  busy_ff !== 1'b1) frozen_bad = 1'b1;
            end
            check("freeze", 32'(frozen_bad), 32'h0);
            ce = 1'b1;
         end
      end
      if (k >= 4000) begin
         fails++;
         tally_and_finish();
      end
   endtask : cmd

   task automatic cmp_q(input string what);
      check(what, 32'(got.size()), 32'(exp.size()));
      foreach (exp[i]) begin
         if (i < got.size()) check(what, 32'(got[i]), 32'(exp[i]));
      end
   endtask : cmp_q

   // A frame after a mode change lets the device settle its synchronisers.
   task automatic set_mode(input logic m);
      page_264 = m;
      cmd(8'h00, 24'h000000, 0);
   endtask : set_mode

   task automatic t_buffer_narrow();
      wq = '{8'ha1, 8'hb2, 8'hc3};
      cmd(OP_BUF_WRITE, 24'hfffffe, 3);
      check("write quiet", 32'(oe_seen), 32'h0);
      exp = '{8'ha1, 8'hb2, 8'hc3};
      cmd(OP_BUF_READ_FAST, 24'hfffffe, 3);
      cmp_q("buf fast");
      cmd(OP_BUF_READ_SLOW, 24'h0000fe, 3);
      cmp_q("buf slow");
      wq = '{8'h5d};
      cmd(OP_BUF_WRITE, 24'h0000fe, 1);
      cmd(OP_BUF_READ_FAST, 24'h0000fe, 2);
      exp = '{8'h5d, 8'hb2};
      cmp_q("load stop");
   endtask : t_buffer_narrow

   task automatic t_array(input logic m);
      logic [7:0] ops[2];
      logic [23:0] a;
      ops = '{OP_READ_FAST, OP_READ_SLOW};
      if (m) begin
         a = 24'h000706;
         exp = '{pat(10'h3, 9'h106), pat(10'h3, 9'h107), pat(10'h0, 9'h0)};
      end else begin
         a = 24'h0002fe;
         exp = '{pat(10'h2, 9'h0fe), pat(10'h2, 9'h0ff), pat(10'h3, 9'h0)};
      end
      freeze_at = 200;
      foreach (ops[k]) begin
         cmd(ops[k], a, 3);
         cmp_q("array");
      end
      freeze_at = -1;
   endtask : t_array

   task automatic t_page_and_refuse();
      cmd(OP_BUF_READ_SLOW, 24'h0000fe, 2);
      exp = '{8'h5d, 8'hb2};
      cmp_q("buf kept");
      cmd(OP_PAGE_READ, 24'h0002fe, 3);
      exp = '{pat(10'h2, 9'h0fe), pat(10'h2, 9'h0ff), pat(10'h2, 9'h0)};
      cmp_q("page read");
      cmd(8'h5a, 24'h0000fe, 2);
      check("unknown data", 32'(got.size()), 32'h0);
      check("unknown quiet", 32'(oe_seen), 32'h0);
   endtask : t_page_and_refuse

   task automatic t_buffer_wide();
      wq = '{8'h3c, 8'h4d, 8'h6e};
      cmd(OP_BUF_WRITE, 24'hfffd06, 3);
      cmd(OP_BUF_READ_FAST, 24'h000106, 3);
      exp = '{8'h3c, 8'h4d, 8'h6e};
      cmp_q("buf wide");
   endtask : t_buffer_wide

   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      set_mode(1'b0);
      t_buffer_narrow();
      t_array(1'b0);
      t_page_and_refuse();
      set_mode(1'b1);
      t_array(1'b1);
      t_buffer_wide();
      tally_and_finish();
   end
endmodule : serial_flash_read_and_buffer_load_tb_top
